// ===== ccr_top.sv
// Operation
// - only power-on reset initialises frequency_control
// - reset value follows the clock mode pins
// - pll2_stop writable modes 0-3, else one
// - pll1_stop writable modes 0,1,4,5, else one
// - clkout_stop floats clock pin; modes 4-6 one
// - reserved bit 4 reads zero, written zero
// - both PLLs, modes 0/1: nine ratio codes
// - only PLL2 running: five ratio codes
// - only PLL1, modes 0/1: core x1/x2/x4
// - PLL1 on pin, modes 4/5: four codes
// - both PLLs halted: ten ratio codes
// - PLL start halts clocks, watchdog counts
// - overflow applies ratio, no watchdog flags
// - modes 4-6 take input clock from pin
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.svh"

module ccr_top (
   input wire logic MCLK_I,
   input wire logic SRST_I,
   input wire logic [2:0] MODE_PINS_I,
   input wire logic WDOG_OVF_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [31:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   output logic PLL1_EN_O,
   output logic PLL2_EN_O,
   output logic CLOCK_IO_PIN_OE_N_O,
   output logic CLK_FROM_PIN_O,
   output logic CLK_HALT_O,
   output logic WDOG_SETTLE_O,
   output ccr_pkg::ccr_clk_type CLK_CFG_O
);

   localparam logic [31:0] FC_ADDR = `CCR_FC_ADDR;

   ccr_pkg::ccr_fc_type fc_r;
   ccr_pkg::ccr_state_type st_r;
   logic [2:0] mode_r;
   logic [7:0] cand;
   logic hit;
   logic go;
   logic wr_ok;
   logic wr_legal;
   logic pll_start;
   ccr_pkg::ccr_clk_type cur_cfg;

   // ==========================================================
   // reset value table
   function automatic logic [7:0] rst_val(input logic [2:0] m);
      logic [7:0] v;
      case (m)
         3'h0: v = `CCR_RST_M01;
         3'h1: v = `CCR_RST_M01;
         3'h2: v = `CCR_RST_M2;
         3'h3: v = `CCR_RST_M3;
         3'h4: v = `CCR_RST_M45;
         3'h5: v = `CCR_RST_M45;
         3'h6: v = `CCR_RST_M6;
         default: v = `CCR_RST_M7;
      endcase
      return v;
   endfunction : rst_val

   // ==========================================================
   // clock mode capture
   // straps are treated as static once reset is released
   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         mode_r <= MODE_PINS_I;
      end
   end

   // ==========================================================
   // write candidate with forced bits
   always_comb begin
      cand = PWDATA_I[7:0];
      cand[`CCR_FC_RSV_BIT] = 1'b0;
      if (mode_r[2]) begin
         cand[`CCR_FC_PLL2_BIT] = 1'b1;
         cand[`CCR_FC_CKO_BIT] = 1'b1;
      end
      // modes 2, 3, 6 (and invalid 7) all carry mode bit 1
      if (mode_r[1]) begin
         cand[`CCR_FC_PLL1_BIT] = 1'b1;
      end
   end

   assign pll_start = ~cand[`CCR_FC_PLL1_BIT] | ~cand[`CCR_FC_PLL2_BIT];

   ccr_ratio_dec u_wr_dec (
      .mode_i(mode_r),
      .fc_i(ccr_pkg::ccr_fc_type'(cand)),
      .legal_o(wr_legal),
      .cfg_o()
   );

   ccr_ratio_dec u_cur_dec (
      .mode_i(mode_r),
      .fc_i(fc_r),
      .legal_o(),
      .cfg_o(cur_cfg)
   );

   // ==========================================================
   // apb slave
   assign hit = (PADDR_I[31:2] == FC_ADDR[31:2]);
   assign go = PSEL_I & PENABLE_I & ~PREADY_O;
   assign wr_ok = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & ~PSLVERR_O;

   // one wait state so every answer leaves a flip-flop
   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h0;
      end else if (go) begin
         PREADY_O <= 1'b1;
         // unlisted codes and writes mid-change are refused
         PSLVERR_O <= ~hit | (PWRITE_I &
                      ((st_r != ccr_pkg::CCR_S_RUN) | ~wr_legal));
         PRDATA_O <= (hit & ~PWRITE_I) ? {24'h0, fc_r} : 32'h0;
      end else begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h0;
      end
   end

   // ==========================================================
   // frequency_control register
   // only the pin reset lands here; watchdog resets never reach it
   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         fc_r <= ccr_pkg::ccr_fc_type'(rst_val(MODE_PINS_I));
      end else if (wr_ok) begin
         fc_r <= ccr_pkg::ccr_fc_type'(cand);
      end
   end

   // ==========================================================
   // change sequencer
   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         st_r <= ccr_pkg::CCR_S_APPLY;
      end else begin
         unique case (st_r)
            ccr_pkg::CCR_S_RUN: begin
               if (wr_ok) begin
                  st_r <= pll_start ? ccr_pkg::CCR_S_SETTLE
                                    : ccr_pkg::CCR_S_APPLY;
               end
            end
            ccr_pkg::CCR_S_SETTLE: begin
               if (WDOG_OVF_I) begin
                  st_r <= ccr_pkg::CCR_S_APPLY;
               end
            end
            ccr_pkg::CCR_S_APPLY: begin
               st_r <= ccr_pkg::CCR_S_RUN;
            end
            default: begin
               st_r <= ccr_pkg::CCR_S_RUN;
            end
         endcase
      end
   end

   // clocks stay held from reset until the first setting is applied
   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         CLK_HALT_O <= 1'b1;
      end else if (st_r == ccr_pkg::CCR_S_RUN && wr_ok && pll_start) begin
         CLK_HALT_O <= 1'b1;
      end else if (st_r == ccr_pkg::CCR_S_APPLY) begin
         CLK_HALT_O <= 1'b0;
      end
   end

   // tells the watchdog to count the oscillator and keep its flags,
   // interrupt and overflow pin quiet for this overflow
   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         WDOG_SETTLE_O <= 1'b0;
      end else if (st_r == ccr_pkg::CCR_S_RUN && wr_ok && pll_start) begin
         WDOG_SETTLE_O <= 1'b1;
      end else if (st_r == ccr_pkg::CCR_S_SETTLE && WDOG_OVF_I) begin
         WDOG_SETTLE_O <= 1'b0;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         CLK_CFG_O <= '0;
      end else if (st_r == ccr_pkg::CCR_S_APPLY) begin
         CLK_CFG_O <= cur_cfg;
      end
   end

   // ==========================================================
   // pll and pin controls
   // plls follow the register at once so they settle meanwhile
   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         PLL1_EN_O <= 1'b0;
         PLL2_EN_O <= 1'b0;
      end else begin
         PLL1_EN_O <= ~fc_r.pll1_stop;
         PLL2_EN_O <= ~fc_r.pll2_stop;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
         CLOCK_IO_PIN_OE_N_O <= 1'b1;
         CLK_FROM_PIN_O <= 1'b0;
      end else begin
         CLOCK_IO_PIN_OE_N_O <= fc_r.clkout_stop;
         CLK_FROM_PIN_O <= mode_r[2];
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (SRST_I);

   property p_rst_val;
      disable iff (1'b0)
      SRST_I |=> fc_r == rst_val($past(MODE_PINS_I));
   endproperty
   a_rst_val: assert property (p_rst_val)
      else $error("frequency_control reset value wrong");

   property p_pll2_forced;
      mode_r[2] |-> fc_r.pll2_stop && !PLL2_EN_O;
   endproperty
   a_pll2_forced: assert property (p_pll2_forced)
      else $error("pll2_stop not forced in pin modes");

   property p_pll1_forced;
      mode_r[1] |-> fc_r.pll1_stop ##1 !PLL1_EN_O;
   endproperty
   a_pll1_forced: assert property (p_pll1_forced)
      else $error("pll1_stop not forced");

   property p_cko_forced;
      mode_r[2] |-> fc_r.clkout_stop ##1 CLOCK_IO_PIN_OE_N_O;
   endproperty
   a_cko_forced: assert property (p_cko_forced)
      else $error("clock pin driven in pin modes");

   property p_rsv_zero;
      PREADY_O && !PWRITE_I |-> PRDATA_O[`CCR_FC_RSV_BIT] == 1'b0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("reserved bit read as one");

   sequence s_start_wr;
      st_r == ccr_pkg::CCR_S_RUN && wr_ok && pll_start;
   endsequence

   sequence s_held;
      CLK_HALT_O && WDOG_SETTLE_O && st_r == ccr_pkg::CCR_S_SETTLE;
   endsequence

   property p_start_halts;
      s_start_wr |=> s_held;
   endproperty
   a_start_halts: assert property (p_start_halts)
      else $error("pll start did not halt clocks");

   property p_hold_cfg;
      st_r == ccr_pkg::CCR_S_SETTLE && !WDOG_OVF_I |=>
         $stable(CLK_CFG_O) && CLK_HALT_O;
   endproperty
   a_hold_cfg: assert property (p_hold_cfg)
      else $error("setting changed before overflow");

   sequence s_ovf;
      st_r == ccr_pkg::CCR_S_SETTLE && WDOG_OVF_I;
   endsequence

   sequence s_applied;
      !WDOG_SETTLE_O ##1 !CLK_HALT_O && CLK_CFG_O == $past(cur_cfg);
   endsequence

   property p_ovf_applies;
      s_ovf |=> s_applied;
   endproperty
   a_ovf_applies: assert property (p_ovf_applies)
      else $error("overflow did not apply new ratio");

   property p_refused;
      PREADY_O && PSLVERR_O && PWRITE_I |=> $stable(fc_r);
   endproperty
   a_refused: assert property (p_refused)
      else $error("refused write changed register");

   // source output still shows its reset value on the release edge
   property p_from_pin;
      !SRST_I |=> CLK_FROM_PIN_O == $past(mode_r[2]);
   endproperty
   a_from_pin: assert property (p_from_pin)
      else $error("clock source does not follow mode");

   property p_rsv_store;
      !fc_r.rsv;
   endproperty
   a_rsv_store: assert property (p_rsv_store)
      else $error("reserved bit stored as one");

   property p_ready_pulse;
      PREADY_O |=> !PREADY_O && !PSLVERR_O;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready held longer than one cycle");

   property p_busy_refused;
      go && PWRITE_I && st_r != ccr_pkg::CCR_S_RUN |=> PSLVERR_O;
   endproperty
   a_busy_refused: assert property (p_busy_refused)
      else $error("write accepted during a change");

   property p_illegal_refused;
      go && PWRITE_I && !wr_legal |=> PSLVERR_O && PREADY_O;
   endproperty
   a_illegal_refused: assert property (p_illegal_refused)
      else $error("unlisted ratio code accepted");

   property p_unmapped;
      go && !hit |=> PSLVERR_O && PRDATA_O == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");

   sequence s_plain_wr;
      st_r == ccr_pkg::CCR_S_RUN && wr_ok && !pll_start;
   endsequence

   property p_plain_apply;
      s_plain_wr |=> !CLK_HALT_O ##0 s_applied;
   endproperty
   a_plain_apply: assert property (p_plain_apply)
      else $error("halted-pll write not applied directly");

endmodule : ccr_top

`default_nettype wire

// ===== ccr_map.svh
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// ==========================================================
// register address
`define CCR_FC_ADDR 32'hfffffe90

// ==========================================================
// frequency_control field positions
`define CCR_FC_PLL2_BIT 7
`define CCR_FC_PLL1_BIT 6
`define CCR_FC_CKO_BIT 5
`define CCR_FC_RSV_BIT 4
`define CCR_FC_RATIO_MSB 3

// ==========================================================
// reset values by clock mode
`define CCR_RST_M01 8'h00
`define CCR_RST_M2 8'h40
`define CCR_RST_M3 8'h60
`define CCR_RST_M45 8'ha6
`define CCR_RST_M6 8'he0
// mode 7 is not a valid strap; every forced bit reads one
`define CCR_RST_M7 8'he0

`endif

// ===== ccr_pkg.sv
package ccr_pkg;

   // ==========================================================
   // clock ratio against the input clock
   typedef enum logic [2:0] {
      CCR_RQ = 3'h0,
      CCR_RH = 3'h1,
      CCR_R1 = 3'h2,
      CCR_R2 = 3'h3,
      CCR_R4 = 3'h4
   } ccr_ratio_type;

   // ==========================================================
   // selected clock tree setting
   typedef struct packed {
      ccr_ratio_type phi;
      ccr_ratio_type core;
      ccr_ratio_type bus;
      ccr_ratio_type periph;
      ccr_ratio_type clkio;
   } ccr_clk_type;

   // ==========================================================
   // frequency_control layout
   typedef struct packed {
      logic pll2_stop;
      logic pll1_stop;
      logic clkout_stop;
      logic rsv;
      logic [3:0] ratio_select;
   } ccr_fc_type;

   // ==========================================================
   // change sequencer
   typedef enum logic [1:0] {
      CCR_S_RUN = 2'h0,
      CCR_S_SETTLE = 2'h1,
      CCR_S_APPLY = 2'h3
   } ccr_state_type;

endpackage : ccr_pkg

// ===== ccr_ratio_dec.sv
`timescale 1ns/1ps
`default_nettype none

module ccr_ratio_dec (
   input wire logic [2:0] mode_i,
   input wire ccr_pkg::ccr_fc_type fc_i,
   output logic legal_o,
   output ccr_pkg::ccr_clk_type cfg_o
);

   logic p1;
   logic p2;
   logic pin;
   logic [15:0] d;

   // ==========================================================
   // digits: phi/core/bus/periph, 0=1/4 1=1/2 2=x1 3=x2 4=x4
   function automatic ccr_pkg::ccr_clk_type mk(input logic [15:0] v,
                                                input logic pin_v);
      ccr_pkg::ccr_clk_type c;
      c.phi = ccr_pkg::ccr_ratio_type'(v[14:12]);
      c.core = ccr_pkg::ccr_ratio_type'(v[10:8]);
      c.bus = ccr_pkg::ccr_ratio_type'(v[6:4]);
      c.periph = ccr_pkg::ccr_ratio_type'(v[2:0]);
      c.clkio = pin_v ? ccr_pkg::CCR_R1 : c.bus;
      return c;
   endfunction : mk

   assign p1 = ~fc_i.pll1_stop;
   assign p2 = ~fc_i.pll2_stop;

   always_comb begin
      d = 16'h2222;
      pin = 1'b0;
      legal_o = 1'b1;
      if (mode_i == 3'h7) begin
         legal_o = 1'b0;
      end else if (p1 && p2) begin
         case (fc_i.ratio_select)
            4'h0: d = 16'h4222;
            4'h4: d = 16'h4322;
            4'h5: d = 16'h4332;
            4'h6: d = 16'h4333;
            4'h8: d = 16'h4422;
            4'h9: d = 16'h4432;
            4'ha: d = 16'h4433;
            4'hc: d = 16'h4442;
            4'he: d = 16'h4443;
            default: legal_o = 1'b0;
         endcase
      end else if (p2) begin
         case (fc_i.ratio_select)
            4'h0: d = 16'h2222;
            4'h5: d = 16'h3332;
            4'h6: d = 16'h3333;
            4'hc: d = 16'h4442;
            4'he: d = 16'h4443;
            default: legal_o = 1'b0;
         endcase
      end else if (p1 && !mode_i[2]) begin
         case (fc_i.ratio_select)
            4'h0: d = 16'h4222;
            4'h4: d = 16'h4322;
            4'h8: d = 16'h4422;
            default: legal_o = 1'b0;
         endcase
      end else if (p1) begin
         pin = 1'b1;
         case (fc_i.ratio_select)
            4'h5: d = 16'h3221;
            4'h6: d = 16'h3222;
            4'h9: d = 16'h3321;
            4'ha: d = 16'h3322;
            default: legal_o = 1'b0;
         endcase
      end else begin
         pin = 1'b1;
         case (fc_i.ratio_select)
            4'h0: d = 16'h2000;
            4'h4: d = 16'h2100;
            4'h5: d = 16'h2110;
            4'h6: d = 16'h2111;
            4'h8: d = 16'h2200;
            4'h9: d = 16'h2210;
            4'ha: d = 16'h2211;
            4'hc: d = 16'h2220;
            4'he: d = 16'h2221;
            4'hf: d = 16'h2222;
            default: legal_o = 1'b0;
         endcase
      end
      cfg_o = mk(d, pin);
   end

endmodule : ccr_ratio_dec

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.svh"

module tb_top;
   // ==========================================================
   // stimulus and observation
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] mode = 3'h0;
   logic ovf = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pll1_en;
   logic pll2_en;
   logic oe_n;
   logic from_pin;
   logic halt;
   logic settle;
   ccr_pkg::ccr_clk_type cfg;
   int err_count = 0;
   int check_count = 0;

   always #2 mclk = ~mclk;

   ccr_top ccr_top_inst (
      .MCLK_I(mclk),
      .SRST_I(srst),
      .MODE_PINS_I(mode),
      .WDOG_OVF_I(ovf),
      .PSEL_I(psel),
      .PENABLE_I(penable),
      .PWRITE_I(pwrite),
      .PADDR_I(paddr),
      .PWDATA_I(pwdata),
      .PRDATA_O(prdata),
      .PREADY_O(pready),
      .PSLVERR_O(pslverr),
      .PLL1_EN_O(pll1_en),
      .PLL2_EN_O(pll2_en),
      .CLOCK_IO_PIN_OE_N_O(oe_n),
      .CLK_FROM_PIN_O(from_pin),
      .CLK_HALT_O(halt),
      .WDOG_SETTLE_O(settle),
      .CLK_CFG_O(cfg)
   );

   // ==========================================================
   // compare and bus helpers
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   // ratio codes: 0=1/4 1=1/2 2=x1 3=x2 4=x4
   function automatic logic [31:0] cv(input logic [2:0] p, c, b, q, k);
      return {17'h0, p, c, b, q, k};
   endfunction : cv

   task automatic apb(input logic wr, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) err_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr_chk(input logic [31:0] a, input logic [7:0] d,
                         input logic e);
      logic [31:0] r;
      logic er;
      apb(1'b1, a, {24'h0, d}, r, er);
      chk_bit(er, e);
   endtask : wr_chk

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] d,
                         input logic e);
      logic [31:0] r;
      logic er;
      apb(1'b0, a, 32'h0, r, er);
      chk_bit(er, e);
      chk_val(r, d);
   endtask : rd_chk

   task automatic do_reset(input logic [2:0] m);
      @(posedge mclk);
      srst <= 1'b1;
      mode <= m;
      repeat (4) @(posedge mclk);
      srst <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
   endtask : do_reset

   task automatic ovf_pulse();
      @(posedge mclk);
      ovf <= 1'b1;
      @(posedge mclk);
      ovf <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
   endtask : ovf_pulse

   // write that starts a PLL, then settle on overflow
   task automatic pll_change(input logic [7:0] wd, input logic [31:0] ce);
      wr_chk(`CCR_FC_ADDR, wd, 1'b0);
      @(posedge mclk);
      #1;
      chk_bit(halt, 1'b1);
      chk_bit(settle, 1'b1);
      ovf_pulse();
      chk_bit(halt, 1'b0);
      chk_bit(settle, 1'b0);
      chk_val(32'(cfg), ce);
   endtask : pll_change

   // ==========================================================
   // scenarios
   task automatic t_reset_values();
      logic [7:0] rv [8];
      rv = '{8'h00, 8'h00, 8'h40, 8'h60, 8'ha6, 8'ha6, 8'he0, 8'he0};
      for (int i = 0; i < 8; i++) begin
         do_reset(3'(i));
         chk_bit(pll2_en, ~rv[i][7]);
         chk_bit(pll1_en, ~rv[i][6]);
         chk_bit(oe_n, rv[i][5]);
         chk_bit(from_pin, i[2]);
         chk_bit(halt, 1'b0);
         if (i == 6) begin
            chk_val(32'(cfg), cv(3'h2, 3'h0, 3'h0, 3'h0, 3'h2));
         end
         if (i == 4) begin
            chk_val(32'(cfg), cv(3'h3, 3'h2, 3'h2, 3'h2, 3'h2));
         end
         rd_chk(`CCR_FC_ADDR, {24'h0, rv[i]}, 1'b0);
      end
      // mode 7 is no legal strap, so no write is accepted
      wr_chk(`CCR_FC_ADDR, 8'hff, 1'b1);
   endtask : t_reset_values

   task automatic t_mode0();
      do_reset(3'h0);
      wr_chk(`CCR_FC_ADDR, 8'hff, 1'b0);
      repeat (3) @(posedge mclk);
      #1;
      chk_bit(halt, 1'b0);
      chk_bit(oe_n, 1'b1);
      chk_val(32'(cfg), cv(3'h2, 3'h2, 3'h2, 3'h2, 3'h2));
      rd_chk(`CCR_FC_ADDR, 32'hef, 1'b0);
      // software has prepared the watchdog beforehand
      wr_chk(`CCR_FC_ADDR, 8'h0a, 1'b0);
      repeat (6) @(posedge mclk);
      #1;
      chk_bit(halt, 1'b1);
      chk_bit(pll1_en, 1'b1);
      chk_bit(oe_n, 1'b0);
      wr_chk(`CCR_FC_ADDR, 8'h00, 1'b1);
      ovf_pulse();
      chk_bit(halt, 1'b0);
      chk_bit(settle, 1'b0);
      chk_val(32'(cfg), cv(3'h4, 3'h4, 3'h3, 3'h3, 3'h3));
      wr_chk(`CCR_FC_ADDR, 8'h07, 1'b1);
      rd_chk(`CCR_FC_ADDR, 32'h0a, 1'b0);
      rd_chk(32'hfffffe94, 32'h0, 1'b1);
      // overflow outside a change acts as an internal reset only
      ovf_pulse();
      rd_chk(`CCR_FC_ADDR, 32'h0a, 1'b0);
      chk_val(32'(cfg), cv(3'h4, 3'h4, 3'h3, 3'h3, 3'h3));
   endtask : t_mode0

   task automatic t_mode1();
      do_reset(3'h1);
      pll_change(8'h88, cv(3'h4, 3'h4, 3'h2, 3'h2, 3'h2));
      chk_bit(pll2_en, 1'b0);
      chk_bit(pll1_en, 1'b1);
   endtask : t_mode1

   task automatic t_mode2();
      do_reset(3'h2);
      pll_change(8'h05, cv(3'h3, 3'h3, 3'h3, 3'h2, 3'h3));
      rd_chk(`CCR_FC_ADDR, 32'h45, 1'b0);
   endtask : t_mode2

   task automatic t_mode4();
      do_reset(3'h4);
      pll_change(8'h0a, cv(3'h3, 3'h3, 3'h2, 3'h2, 3'h2));
      rd_chk(`CCR_FC_ADDR, 32'haa, 1'b0);
      chk_bit(from_pin, 1'b1);
      chk_bit(oe_n, 1'b1);
   endtask : t_mode4

   // ==========================================================
   // verdict and run control
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   initial begin
      #40000;
      err_count++;
      print_verdict();
   end

   initial begin
      t_reset_values();
      t_mode0();
      t_mode1();
      t_mode2();
      t_mode4();
      print_verdict();
   end
endmodule : tb_top

`default_nettype wire
